// file: mdc_config_regs.sv
/*
 * Configuration register bank of a three-phase motor driver: gate driver
 * control, sense amplifier control and system control, plus the per-phase
 * dead-time and delay-compensation gating they steer.
 * Assumes a serial frame decoder in front of it that presents one register
 * access per strobe, synchronous to sys_clk, with parity bit 15 untouched.
 */
//
// Contract
// - with parity enabled bit 15 of each read word carries parity, else zero.
// - gate driver bit 7 enables delay compensation; resets to off.
// - dead-time code zero inserts nothing; only the on/off handshake applies.
// - dead-time codes 1 to 7 insert code times 200 ns.
// - gate driver bits 1:0 select slew rate, codes 0 to 3, reset 0.
// - sense amp bit 3 enables the amplifiers; resets to one.
// - sense amp bits 1:0 select gain, codes 0 to 3, reset 0.
// - system control bit 7 holds register lock; resets unlocked.
// - system control bit 6 enables parity check and generation; resets off.
// - sense amp control sits at 0x23, resets to 0x0008.
// - system control sits at 0x3f, resets to all zeros.
// - with compensation on, edges are delayed to propagation plus dead time.
`timescale 1ns/1ps
`include "mdc_regs.svh"

module mdc_config_regs
    import mdc_pkg::*;
#(
    parameter int PROP_DELAY_NS = 100
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register access from the serial frame decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_wr_done,
    output logic reg_wr_rejected,
    // configuration towards the analog stages
    output mdc_cfg_s cfg,
    // phase gate commands in and gated drive out
    input mdc_gate_s gate_cmd,
    output mdc_gate_s gate_drive
);

    localparam int COMP_CYC_I = (PROP_DELAY_NS * `MDC_CLK_MHZ) / 1000;
    // floor of one cycle keeps compensation visible even at a slow clock
    localparam logic [7:0] COMP_CYC = (COMP_CYC_I < 1) ? 8'h01 : 8'(COMP_CYC_I);
    localparam logic [7:0] DEAD_STEP = 8'(`MDC_DEAD_STEP_CYC);

    // even parity over the low fifteen bits
    function automatic logic parity15(input logic [15:0] w);
        parity15 = ^w[14:0];
    endfunction

    function automatic logic [7:0] dead_cycles(input logic [2:0] code);
        dead_cycles = 8'(code * DEAD_STEP);
    endfunction

    // register map decode, shared by the write and read paths
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_GDC = 2'h1;
    localparam logic [1:0] SEL_SAC = 2'h2;
    localparam logic [1:0] SEL_SYC = 2'h3;

    function automatic logic [1:0] reg_sel(input logic [5:0] a);
        case (a)
            `MDC_ADDR_GATE_DRIVER_CONTROL: reg_sel = SEL_GDC;
            `MDC_ADDR_SENSE_AMP_CONTROL: reg_sel = SEL_SAC;
            `MDC_ADDR_SYSTEM_CONTROL: reg_sel = SEL_SYC;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // stored images; bit 15 is never set in them, but reserved bits 11:8 (gate driver) and 8, 5:0 (system) are stored as written
    logic [15:0] gdc;
    logic [15:0] sac;
    logic [15:0] syc;
    logic [15:0] next_gdc;
    logic [15:0] next_sac;
    logic [15:0] next_syc;
    logic [15:0] rdata_q;
    logic [15:0] next_rdata;
    logic rd_valid_q;
    logic wr_done_q;
    logic wr_rej_q;
    logic next_wr_rej;
    logic [15:0] rd_word;
    logic parity_ok;
    logic locked;

    assign locked = syc[`MDC_BIT_REG_LOCK];
    // a frame with bad parity is discarded only while checking is on
    assign parity_ok = !syc[`MDC_BIT_PARITY_EN] ||
                       (reg_wdata[`MDC_BIT_PARITY] == parity15(reg_wdata));

    // a rejected write leaves every register as it was; the host learns of it
    // only through reg_wr_rejected, there is no retry in the bank
    always_comb begin
        next_gdc = gdc;
        next_sac = sac;
        next_syc = syc;
        next_wr_rej = 1'b0;
        if (reg_wr_en) begin
            if (!parity_ok) begin
                next_wr_rej = 1'b1;
            end else begin
                case (reg_sel(reg_addr))
                    SEL_GDC: begin
                        if (locked) begin
                            next_wr_rej = 1'b1;
                        end else begin
                            next_gdc = 16'h0000;
                            next_gdc[`MDC_BIT_DELAY_COMP] = reg_wdata[`MDC_BIT_DELAY_COMP];
                            next_gdc[`MDC_DEAD_MSB:`MDC_DEAD_LSB] =
                                reg_wdata[`MDC_DEAD_MSB:`MDC_DEAD_LSB];
                            next_gdc[`MDC_SLEW_MSB:`MDC_SLEW_LSB] =
                                reg_wdata[`MDC_SLEW_MSB:`MDC_SLEW_LSB];
                            next_gdc[`MDC_GDC_RSVD_MSB:`MDC_GDC_RSVD_LSB] =
                                reg_wdata[`MDC_GDC_RSVD_MSB:`MDC_GDC_RSVD_LSB];
                        end
                    end
                    SEL_SAC: begin
                        if (locked) begin
                            next_wr_rej = 1'b1;
                        end else begin
                            next_sac = 16'h0000;
                            next_sac[`MDC_BIT_SENSE_EN] = reg_wdata[`MDC_BIT_SENSE_EN];
                            next_sac[`MDC_GAIN_MSB:`MDC_GAIN_LSB] =
                                reg_wdata[`MDC_GAIN_MSB:`MDC_GAIN_LSB];
                        end
                    end
                    SEL_SYC: begin
                        // stays writable while locked, otherwise nothing could unlock
                        if (reg_wdata[`MDC_KEY_MSB:`MDC_KEY_LSB] != `MDC_KEY_VALUE) begin
                            next_wr_rej = 1'b1;
                        end else begin
                            next_syc = 16'h0000;
                            next_syc[`MDC_BIT_REG_LOCK] = reg_wdata[`MDC_BIT_REG_LOCK];
                            next_syc[`MDC_BIT_PARITY_EN] = reg_wdata[`MDC_BIT_PARITY_EN];
                            next_syc[`MDC_SYS_RSVD_BIT8] = reg_wdata[`MDC_SYS_RSVD_BIT8];
                            next_syc[`MDC_SYS_RSVD_MSB:`MDC_SYS_RSVD_LSB] =
                                reg_wdata[`MDC_SYS_RSVD_MSB:`MDC_SYS_RSVD_LSB];
                        end
                    end
                    default: begin
                        next_wr_rej = 1'b1;
                    end
                endcase
            end
        end
    end

    // key field is write-only and never stored, so it reads back as zero
    always_comb begin
        case (reg_sel(reg_addr))
            SEL_GDC: rd_word = gdc;
            SEL_SAC: rd_word = sac;
            SEL_SYC: rd_word = syc;
            default: rd_word = 16'h0000;
        endcase
        rd_word[`MDC_BIT_PARITY] = 1'b0;
        // parity follows the enable in force at the read edge, so a read in the
        // same cycle as the enabling write still comes back without it
        next_rdata = rdata_q;
        if (reg_rd_en) begin
            next_rdata = rd_word;
            if (syc[`MDC_BIT_PARITY_EN]) begin
                next_rdata[`MDC_BIT_PARITY] = parity15(rd_word);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gdc <= `MDC_RST_GATE_DRIVER_CONTROL;
            sac <= `MDC_RST_SENSE_AMP_CONTROL;
            syc <= `MDC_RST_SYSTEM_CONTROL;
            rdata_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            wr_done_q <= 1'b0;
            wr_rej_q <= 1'b0;
        end else begin
            gdc <= next_gdc;
            sac <= next_sac;
            syc <= next_syc;
            rdata_q <= next_rdata;
            rd_valid_q <= reg_rd_en;
            wr_done_q <= reg_wr_en;
            wr_rej_q <= next_wr_rej;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign reg_wr_done = wr_done_q;
    assign reg_wr_rejected = wr_rej_q;

    // configuration leaves straight from the stored images, no extra stage,
    // so a write is in force from the edge that takes it
    assign cfg.delay_comp_enable = gdc[`MDC_BIT_DELAY_COMP];
    assign cfg.dead_time_select = gdc[`MDC_DEAD_MSB:`MDC_DEAD_LSB];
    assign cfg.slew_rate_select = gdc[`MDC_SLEW_MSB:`MDC_SLEW_LSB];
    assign cfg.sense_amp_enable = sac[`MDC_BIT_SENSE_EN];
    assign cfg.sense_amp_gain = sac[`MDC_GAIN_MSB:`MDC_GAIN_LSB];
    assign cfg.reg_lock = syc[`MDC_BIT_REG_LOCK];
    assign cfg.serial_parity_enable = syc[`MDC_BIT_PARITY_EN];

    // per-phase gating: on any command change both switches go off for the
    // blanking time, then the newest command is applied
    // limitation: a change during blanking does not restart it, so a pulse
    // shorter than the blanking never reaches the switches
    mdc_phase_e ph_st [3];
    mdc_phase_e next_ph_st [3];
    logic [7:0] ph_cnt [3];
    logic [7:0] next_ph_cnt [3];
    logic [1:0] ph_out [3];
    logic [1:0] next_ph_out [3];
    logic [1:0] ph_last [3];
    logic [1:0] next_ph_last [3];
    logic [7:0] blank_cyc;

    // compensation only stretches the blanking to its target; per-edge
    // trimming belongs to the analog stage
    always_comb begin
        blank_cyc = dead_cycles(gdc[`MDC_DEAD_MSB:`MDC_DEAD_LSB]);
        if (gdc[`MDC_BIT_DELAY_COMP]) begin
            blank_cyc = 8'(blank_cyc + COMP_CYC);
        end
    end

    always_comb begin
        logic [1:0] cmd;
        cmd = 2'b00;
        for (int i = 0; i < 3; i++) begin
            // both-on request is never passed: treated as both off
            cmd = {gate_cmd.high[i], gate_cmd.low[i]};
            if (cmd == 2'b11) begin
                cmd = 2'b00;
            end
            next_ph_st[i] = ph_st[i];
            next_ph_cnt[i] = ph_cnt[i];
            next_ph_out[i] = ph_out[i];
            next_ph_last[i] = cmd;
            case (ph_st[i])
                MDC_PH_PASS: begin
                    if (cmd != ph_last[i]) begin
                        if (blank_cyc == 8'h00) begin
                            next_ph_out[i] = cmd;
                        end else begin
                            next_ph_out[i] = 2'b00;
                            next_ph_cnt[i] = blank_cyc;
                            next_ph_st[i] = MDC_PH_BLANK;
                        end
                    end
                end
                MDC_PH_BLANK: begin
                    if (ph_cnt[i] <= 8'h01) begin
                        next_ph_out[i] = cmd;
                        next_ph_cnt[i] = 8'h00;
                        next_ph_st[i] = MDC_PH_PASS;
                    end else begin
                        next_ph_cnt[i] = ph_cnt[i] - 8'h01;
                    end
                end
                default: begin
                    next_ph_st[i] = MDC_PH_PASS;
                    next_ph_out[i] = 2'b00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                ph_st[i] <= MDC_PH_PASS;
                ph_cnt[i] <= 8'h00;
                ph_out[i] <= 2'b00;
                ph_last[i] <= 2'b00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                ph_st[i] <= next_ph_st[i];
                ph_cnt[i] <= next_ph_cnt[i];
                ph_out[i] <= next_ph_out[i];
                ph_last[i] <= next_ph_last[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gate_drive.high[i] = ph_out[i][1];
            gate_drive.low[i] = ph_out[i][0];
        end
    end

endmodule

// file: mdc_regs.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * motor driver configuration register bank.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH

// register offsets (6-bit register address)
`define MDC_ADDR_GATE_DRIVER_CONTROL 6'h22
`define MDC_ADDR_SENSE_AMP_CONTROL 6'h23
`define MDC_ADDR_SYSTEM_CONTROL 6'h3f

// reset values
`define MDC_RST_GATE_DRIVER_CONTROL 16'h0000
`define MDC_RST_SENSE_AMP_CONTROL 16'h0008
`define MDC_RST_SYSTEM_CONTROL 16'h0000

// common field
`define MDC_BIT_PARITY 15

// gate driver control fields
`define MDC_BIT_DELAY_COMP 7
`define MDC_DEAD_MSB 6
`define MDC_DEAD_LSB 4
`define MDC_SLEW_MSB 1
`define MDC_SLEW_LSB 0
`define MDC_GDC_RSVD_MSB 11
`define MDC_GDC_RSVD_LSB 8

// sense amp control fields
`define MDC_BIT_SENSE_EN 3
`define MDC_GAIN_MSB 1
`define MDC_GAIN_LSB 0

// system control fields
`define MDC_KEY_MSB 14
`define MDC_KEY_LSB 12
`define MDC_KEY_VALUE 3'h5
`define MDC_BIT_REG_LOCK 7
`define MDC_BIT_PARITY_EN 6
`define MDC_SYS_RSVD_BIT8 8
`define MDC_SYS_RSVD_MSB 5
`define MDC_SYS_RSVD_LSB 0

// timing
`define MDC_CLK_MHZ 125
`define MDC_DEAD_STEP_NS 200
`define MDC_DEAD_STEP_CYC (((`MDC_DEAD_STEP_NS * `MDC_CLK_MHZ) + 999) / 1000)

`endif

// file: mdc_pkg.sv
/*
 * Types shared by the motor driver configuration register bank.
 * Assumes mdc_regs.svh is on the include path.
 */
package mdc_pkg;

    typedef enum logic {
        MDC_PH_PASS = 1'b0,
        MDC_PH_BLANK = 1'b1
    } mdc_phase_e;

    typedef struct packed {
        logic delay_comp_enable;
        logic [2:0] dead_time_select;
        logic [1:0] slew_rate_select;
        logic sense_amp_enable;
        logic [1:0] sense_amp_gain;
        logic reg_lock;
        logic serial_parity_enable;
    } mdc_cfg_s;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } mdc_gate_s;

endpackage

// file: mdc_config_props.sv
/* Port checker for the motor driver config bank.
   Assumes binding to mdc_config_regs; sees its ports only. */
`timescale 1ns/1ps
`include "mdc_regs.svh"
module mdc_config_props
    import mdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register access
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_done,
    input wire logic reg_wr_rejected,
    // configuration
    input wire mdc_cfg_s cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // writes that the bank must take, parity off keeps bit 15 out of play
    logic w_gdc, w_sac, w_sys, key_ok;
    assign w_gdc = reg_wr_en && reg_addr == `MDC_ADDR_GATE_DRIVER_CONTROL;
    assign w_sac = reg_wr_en && reg_addr == `MDC_ADDR_SENSE_AMP_CONTROL;
    assign w_sys = reg_wr_en && reg_addr == `MDC_ADDR_SYSTEM_CONTROL;
    assign key_ok = reg_wdata[14:12] == `MDC_KEY_VALUE;
    a_wr_answer: assert property (reg_wr_en |=> reg_wr_done) else $error("write not answered");
    a_no_stray_done: assert property (!reg_wr_en |=> !reg_wr_done && !reg_wr_rejected)
        else $error("stray write answer");
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
    a_bad_key: assert property (w_sys && !key_ok |=> reg_wr_rejected && $stable(cfg))
        else $error("wrong key accepted");
    a_lock_discard: assert property ((w_sac || w_gdc) && cfg.reg_lock |=> reg_wr_rejected && $stable(cfg))
        else $error("locked write accepted");
    a_gdc_fields: assert property (w_gdc && !cfg.reg_lock && !cfg.serial_parity_enable
        |=> {cfg.delay_comp_enable, cfg.dead_time_select} == $past(reg_wdata[7:4])) else $error("gdc fields wrong");
    a_sys_fields: assert property (w_sys && key_ok && !cfg.serial_parity_enable
        |=> {cfg.reg_lock, cfg.serial_parity_enable} == $past(reg_wdata[7:6])) else $error("sys fields wrong");
    a_parity_low: assert property (reg_rd_en && !reg_wr_en && !cfg.serial_parity_enable |=> !reg_rdata[15])
        else $error("parity bit set while off");
    a_parity_even: assert property (reg_rd_en && !reg_wr_en && cfg.serial_parity_enable
        |=> reg_rdata[15] == ^reg_rdata[14:0]) else $error("read parity wrong");
    c_rejected: cover property (reg_wr_done && reg_wr_rejected);
    c_locked: cover property (w_sac && cfg.reg_lock);
    c_parity_rd: cover property (reg_rd_en && cfg.serial_parity_enable);
endmodule
bind mdc_config_regs mdc_config_props props (.sys_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_wr_done, .reg_wr_rejected, .cfg);

// file: mdc_host.sv
/* Host model issuing register accesses to the bank.
   Assumes the bench calls its tasks; drives at falling edges. */
`timescale 1ns/1ps
`include "mdc_regs.svh"
module mdc_host
    import mdc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // register access
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [5:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_done,
    input wire logic reg_wr_rejected
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
    end
    function automatic logic [15:0] sys_word(input logic [11:0] ctl);
        return {1'b0, `MDC_KEY_VALUE, ctl};
    endfunction
    function automatic logic [15:0] par(input logic [15:0] w);
        return {^w[14:0], w[14:0]};
    endfunction
    // missing answer yields unknown so the caller's compare fails
    task automatic wr(input logic [5:0] a, input logic [15:0] w, output logic rej);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = w;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~w;
        rej = (reg_wr_done === 1'b1) ? reg_wr_rejected : 1'bx;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] w);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        w = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule

// file: tb_mdc_config_regs.sv
/* Self-checking bench of the motor driver config bank.
   Assumes mdc_host as register master and the bound checker. */
`timescale 1ns/1ps
`include "mdc_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_mdc_config_regs
    import mdc_pkg::*;
;
    localparam logic [5:0] AG = `MDC_ADDR_GATE_DRIVER_CONTROL;
    localparam logic [5:0] AS = `MDC_ADDR_SENSE_AMP_CONTROL;
    localparam logic [5:0] AY = `MDC_ADDR_SYSTEM_CONTROL;
    logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr_en, reg_rd_en, reg_rd_valid, reg_wr_done, reg_wr_rejected, r;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    mdc_cfg_s cfg;
    mdc_gate_s gate_cmd = 6'b001000, gate_drive;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    mdc_host host (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
        .reg_wr_done, .reg_wr_rejected);
    mdc_config_regs dut (.sys_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rd_valid, .reg_wr_done, .reg_wr_rejected, .cfg, .gate_cmd, .gate_drive);
    always #4 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic t_reset();
        mdc_cfg_s e;
        e = '0;
        e.sense_amp_enable = 1'b1;
        `CHK("cfg rst", e, cfg)
        host.rd(AG, d);
        `CHK("gdc rst", 16'h0000, d)
        host.rd(AS, d);
        `CHK("sac rst", 16'h0008, d)
        host.rd(AY, d);
        `CHK("sys rst", 16'h0000, d)
    endtask
    // reset in mid-run while locked with parity on must restore every default
    task automatic t_rst_mid();
        host.wr(AY, host.sys_word(12'h0c0), r);
        `CHK("lock par", 2'b11, {cfg.reg_lock, cfg.serial_parity_enable})
        arst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
    endtask
    task automatic t_fields();
        host.wr(AG, 16'h7fff, r);
        `CHK("wr ok", 1'b0, r)
        `CHK("comp on", 1'b1, cfg.delay_comp_enable)
        host.rd(AG, d);
        `CHK("gdc rd", 16'h0ff3, d)
        for (int i = 0; i < 4; i++) begin
            host.wr(AG, {14'h0, i[1:0]}, r);
            host.wr(AS, {14'h2, i[1:0]}, r);
            `CHK("slew", i[1:0], cfg.slew_rate_select)
            `CHK("gain", i[1:0], cfg.sense_amp_gain)
        end
        host.wr(AS, 16'hfff7, r);
        host.rd(AS, d);
        `CHK("sac rd", 16'h0003, d)
        `CHK("sa off", 1'b0, cfg.sense_amp_enable)
        host.wr(6'h10, 16'h0003, r);
        `CHK("unmapped wr", 1'b1, r)
        host.rd(6'h10, d);
        `CHK("unmapped rd", 16'h0000, d)
    endtask
    task automatic t_lock();
        host.wr(AY, 16'h4080, r);
        `CHK("bad key", 1'b1, r)
        `CHK("no lock", 1'b0, cfg.reg_lock)
        host.wr(AY, host.sys_word(12'hfbf), r);
        `CHK("locked", 1'b1, cfg.reg_lock)
        host.rd(AY, d);
        `CHK("sys rd", 16'h01bf, d)
        host.wr(AS, 16'h0001, r);
        `CHK("lock wr", 1'b1, r)
        host.rd(AS, d);
        `CHK("sac kept", 16'h0003, d)
        host.wr(AY, host.sys_word(12'h000), r);
        `CHK("unlock", 1'b0, cfg.reg_lock)
    endtask
    task automatic t_parity();
        host.wr(AY, host.sys_word(12'h040), r);
        `CHK("par en", 1'b1, cfg.serial_parity_enable)
        host.rd(AY, d);
        `CHK("par rd", 16'h8040, d)
        host.wr(AG, 16'h8003, r);
        `CHK("par bad", 1'b1, r)
        host.wr(AG, host.par(16'h0002), r);
        `CHK("par ok", 1'b0, r)
        host.wr(AY, host.par(host.sys_word(12'h000)), r);
        host.rd(AG, d);
        `CHK("par off", 16'h0002, d)
    endtask
    // gap of 300 cycles outlasts the longest blanking
    task automatic t_dead(input logic [2:0] code, input logic comp);
        int b, n;
        b = code * `MDC_DEAD_STEP_CYC + (comp ? 100 * `MDC_CLK_MHZ / 1000 : 0);
        host.wr(AG, {8'h00, comp, code, 4'h0}, r);
        gate_cmd = 6'b001000;
        repeat (300) @(negedge sys_clk);
        gate_cmd = 6'b000001;
        @(negedge sys_clk);
        n = 1;
        if (b > 0) `CHK("blank", 6'h00, gate_drive)
        while (gate_drive !== gate_cmd && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("delay", 1 + b, n)
        // both switches asked on at once must never reach the outputs
        gate_cmd = 6'b001001;
        repeat (300) @(negedge sys_clk);
        `CHK("both on", 6'h00, gate_drive)
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_fields();
        t_lock();
        t_parity();
        t_rst_mid();
        t_dead(3'd0, 1'b0);
        t_dead(3'd1, 1'b0);
        t_dead(3'd7, 1'b0);
        t_dead(3'd0, 1'b1);
        t_dead(3'd2, 1'b1);
        complete_run();
    end
endmodule
